// ==== low_power_timer.sv ====
// low power timer: time counter or pulse counter with compare and trigger
// assumes presetn is driven only by power-on or low-voltage reset, and
// prescaler clocks and pulse inputs arrive asynchronously as plain levels
`timescale 1ns/1ps

// Contract
// - select field routes prescaler clock 0..3 for codes 00..11
// - bits 31..16 of compare and count registers read zero
// - match then increment sets flag and trigger until next increment
// - compare zero without free-run keeps trigger asserted until timer disabled
// - count register write captures counter; reads return the capture
// - state reset only by power-on or low-voltage reset
// - unfiltered pulse mode counts input directly, no prescaler clock
// - one shared block divides or filters depending on mode
// - divider ticks every 2^1..2^16 edges, first one delayed
// - bypassed time mode counts each prescaler edge, first delayed
// - filter output starts asserted when first enabled
// - filter follows input after 2^1..2^15 steady edges
// - filter samples input only on prescaler rising edges
// - filtered pulse counts each filter assertion, rate limited
// - unfiltered input forced asserted before enable, no false count
// - divide code gives ratio 2^(code+1); filter 2^code, code 0 odd
// - bypass one feeds clock or input direct, zero feeds divider or filter
// - counter clears when disabled, on overflow, or on non-free match
// - flag cleared by disable or writing one; irq is flag and enable
module low_power_timer
  import lptimer_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           ce,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [lptimer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [lptimer_pkg::DATA_W-1:0] pwdata,
  output logic                                pready,
  output logic      [lptimer_pkg::DATA_W-1:0] prdata,
  output logic                                pslverr,
  input  wire logic [lptimer_pkg::SRC_N-1:0]  presc_clk_in,
  input  wire logic [lptimer_pkg::SRC_N-1:0]  pulse_in,
  output logic                                hw_trigger,
  output logic                                timer_irq
);

  import lptimer_pkg::*;

  generate
    if (CNT_W < 1 || CNT_W > 16)
    begin : g_chk
      $error("CNT_W must lie between 1 and 16");
    end
  endgenerate

  // configuration
  logic             en_reg;
  logic             pulse_mode_reg;
  logic             free_reg;
  logic             pol_low_reg;
  logic [SEL_W-1:0] in_sel_reg;
  logic             ie_reg;
  logic [SEL_W-1:0] pcs_reg;
  logic             byp_reg;
  logic [PRE_W-1:0] pre_reg;
  logic [CNT_W-1:0] compare_value_reg;
  logic [CNT_W-1:0] count_capture_reg;

  // state
  logic [CNT_W-1:0]   count_reg;
  logic               flag_reg;
  logic               trig_reg;
  logic [7:0]         sync1_reg;
  logic [7:0]         sync2_reg;
  logic               clk_prev_reg;
  logic               in_prev_reg;
  logic [PRESC_W-1:0] presc_cnt_reg;
  logic               filt_out_reg;
  logic [DATA_W-1:0]  prdata_reg;
  run_state_t         run_state_reg;
  run_state_t         run_state_next;

  // bus decode
  logic acc_wr;
  logic setup_rd;
  logic addr_hit;
  assign acc_wr   = psel & penable & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign addr_hit = (paddr == CSR_OFFSET) || (paddr == PSR_OFFSET) ||
                    (paddr == CMP_OFFSET) || (paddr == CNT_OFFSET);

  // zero wait states; read data is staged in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata  = prdata_reg;

  // selected sources
  logic run;
  logic clk_lvl;
  logic presc_rise;
  logic in_asserted;
  // gated by enable so ticks stop once a disable write clears en_reg, a cycle before the state
  assign run = (run_state_reg == ST_RUN) & en_reg;
  assign clk_lvl    = sync2_reg[pcs_reg];
  assign presc_rise = clk_lvl & ~clk_prev_reg;
  assign in_asserted = sync2_reg[SRC_N + in_sel_reg] ^ pol_low_reg;

  // shared divider and filter limits
  logic [PRESC_W-1:0] div_last;
  logic [PRESC_W-1:0] filt_last;
  // ratio 2^(code+1); filter needs 2^code, code zero taken as one
  assign div_last  = PRESC_W'((32'd2 << pre_reg) - 32'd1);
  assign filt_last = (pre_reg == '0) ? PRESC_W'(1) :
                     PRESC_W'((32'd1 << pre_reg) - 32'd1);

  logic div_tick;
  logic filt_tick;
  logic direct_tick;
  logic tick;
  logic match;
  assign div_tick  = run & ~pulse_mode_reg & ~byp_reg & presc_rise &
                     (presc_cnt_reg == div_last);
  assign filt_tick = run & pulse_mode_reg & ~byp_reg & presc_rise &
                     (presc_cnt_reg == filt_last) & in_asserted &
                     ~filt_out_reg;
  // unfiltered input counts with no prescaler clock
  assign direct_tick = run & byp_reg &
                       (pulse_mode_reg ? (in_asserted & ~in_prev_reg)
                                       : presc_rise);
  // bypass picks direct source over divider/filter
  assign tick  = byp_reg ? direct_tick : (div_tick | filt_tick);
  assign match = tick & (count_reg == compare_value_reg);

  assign hw_trigger = trig_reg;
  assign timer_irq  = flag_reg & ie_reg;

  // async reset here is only power-on or low-voltage reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end
    else if (ce)
    begin
      sync1_reg <= {pulse_in, presc_clk_in};
      sync2_reg <= sync1_reg;
    end
  end

  // edge detect on the selected, synchronised clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_prev_reg <= 1'b0;
    else if (ce)
      clk_prev_reg <= clk_lvl;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_prev_reg <= 1'b1;
    else if (ce)
      in_prev_reg <= run ? in_asserted : 1'b1;
  end

  // start-up: first prescaler edge after enable only arms the block, unless bypassed in pulse mode
  always_comb
  begin
    run_state_next = run_state_reg;
    case (run_state_reg)
      ST_IDLE:
        if (en_reg)
          run_state_next = ST_SYNC;
      ST_SYNC:
        if (!en_reg)
          run_state_next = ST_IDLE;
        // extra synchronising edge before first count
        // same delay in bypassed time mode; bypassed pulse mode needs no edge
        else if ((pulse_mode_reg & byp_reg) | presc_rise)
          run_state_next = ST_RUN;
      ST_RUN:
        if (!en_reg)
          run_state_next = ST_IDLE;
      default:
        run_state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_state_reg <= ST_IDLE;
    else if (ce)
      run_state_reg <= run_state_next;
  end

  // one counter serves as divider or glitch filter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_cnt_reg <= '0;
      filt_out_reg  <= 1'b1;
    end
    else if (ce)
    begin
      if (!run)
      begin
        presc_cnt_reg <= '0;
        filt_out_reg  <= 1'b1;
      end
      else if (presc_rise && !byp_reg)
      begin
        if (!pulse_mode_reg)
          presc_cnt_reg <= (presc_cnt_reg == div_last) ? '0 :
                           presc_cnt_reg + 1'b1;
        else if (in_asserted == filt_out_reg)
          presc_cnt_reg <= '0;
        // follow input after 2^code steady edges, two for code zero
        else if (presc_cnt_reg == filt_last)
        begin
          presc_cnt_reg <= '0;
          filt_out_reg  <= in_asserted;
        end
        else
          presc_cnt_reg <= presc_cnt_reg + 1'b1;
      end
    end
  end

  // clear on disable, wrap on overflow, clear on non-free match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= '0;
    else if (ce)
    begin
      if (!en_reg)
        count_reg <= '0;
      else if (match && !free_reg)
        count_reg <= '0;
      else if (tick)
        count_reg <= count_reg + 1'b1;
    end
  end

  // flag on match; set beats a same-cycle clear
  // cleared by disable or by writing one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_reg <= 1'b0;
    else if (ce)
    begin
      if (!en_reg)
        flag_reg <= 1'b0;
      else if (match)
        flag_reg <= 1'b1;
      else if (acc_wr && paddr == CSR_OFFSET && pwdata[CSR_FLAG_BIT])
        flag_reg <= 1'b0;
    end
  end

  // zero compare without free-run holds it until disable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_reg <= 1'b0;
    else if (ce)
    begin
      if (!en_reg)
        trig_reg <= 1'b0;
      else if (match)
        trig_reg <= 1'b1;
      else if (tick && !(compare_value_reg == '0 && !free_reg))
        trig_reg <= 1'b0;
    end
  end

  // software configuration; prescale fields are trusted to be static
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_reg         <= 1'b0;
      pulse_mode_reg <= 1'b0;
      free_reg       <= 1'b0;
      pol_low_reg    <= 1'b0;
      in_sel_reg     <= '0;
      ie_reg         <= 1'b0;
      pcs_reg        <= '0;
      byp_reg        <= 1'b0;
      pre_reg        <= '0;
      compare_value_reg <= '0;
    end
    else if (ce && acc_wr)
    begin
      case (paddr)
        CSR_OFFSET:
        begin
          en_reg         <= pwdata[CSR_EN_BIT];
          pulse_mode_reg <= pwdata[CSR_MODE_BIT];
          free_reg       <= pwdata[CSR_FREE_BIT];
          pol_low_reg    <= pwdata[CSR_POL_BIT];
          in_sel_reg     <= pwdata[CSR_SEL_LSB +: SEL_W];
          ie_reg         <= pwdata[CSR_IE_BIT];
        end
        PSR_OFFSET:
        begin
          pcs_reg <= pwdata[PSR_PCS_LSB +: SEL_W];
          byp_reg <= pwdata[PSR_BYP_BIT];
          pre_reg <= pwdata[PSR_PRE_LSB +: PRE_W];
        end
        // compare field in the low bits
        CMP_OFFSET:
          compare_value_reg <= pwdata[CNT_W-1:0];
        default:
          ;
      endcase
    end
  end

  // any write to the count register snapshots the counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_capture_reg <= '0;
    else if (ce && acc_wr && paddr == CNT_OFFSET)
      count_capture_reg <= count_reg;
  end

  // upper bits of compare and count read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= REG_RESET;
    else if (ce && setup_rd)
    begin
      prdata_reg <= REG_RESET;
      case (paddr)
        CSR_OFFSET:
        begin
          prdata_reg[CSR_EN_BIT]               <= en_reg;
          prdata_reg[CSR_MODE_BIT]             <= pulse_mode_reg;
          prdata_reg[CSR_FREE_BIT]             <= free_reg;
          prdata_reg[CSR_POL_BIT]              <= pol_low_reg;
          prdata_reg[CSR_SEL_LSB +: SEL_W]     <= in_sel_reg;
          prdata_reg[CSR_IE_BIT]               <= ie_reg;
          prdata_reg[CSR_FLAG_BIT]             <= flag_reg;
        end
        PSR_OFFSET:
        begin
          prdata_reg[PSR_PCS_LSB +: SEL_W] <= pcs_reg;
          prdata_reg[PSR_BYP_BIT]          <= byp_reg;
          prdata_reg[PSR_PRE_LSB +: PRE_W] <= pre_reg;
        end
        CMP_OFFSET:
          prdata_reg[CNT_W-1:0] <= compare_value_reg;
        CNT_OFFSET:
          prdata_reg[CNT_W-1:0] <= count_capture_reg;
        default:
          ;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  upper_zero_a : assert property (
    (ce && setup_rd) |=> (prdata[31:16] == 16'h0000))
    else $error("upper read bits not zero");

  flag_trig_a : assert property (
    (ce && match) |=> (flag_reg && hw_trigger))
    else $error("match did not raise flag and trigger");

  trig_drop_a : assert property (
    (ce && tick && !match && en_reg && compare_value_reg != '0)
    |=> !hw_trigger)
    else $error("trigger not dropped on next increment");

  zero_hold_a : assert property (
    (ce && hw_trigger && en_reg && compare_value_reg == '0 && !free_reg)
    |=> hw_trigger)
    else $error("zero compare trigger released while enabled");

  capture_a : assert property (
    (ce && acc_wr && paddr == CNT_OFFSET) |=>
    (count_capture_reg == $past(count_reg)))
    else $error("count capture wrong");

  direct_pulse_a : assert property (
    (ce && run && pulse_mode_reg && byp_reg && in_asserted && !in_prev_reg
     && en_reg && !match) |=> (count_reg == $past(count_reg) + 1'b1))
    else $error("direct pulse not counted");

  div_rate_a : assert property (
    (ce && div_tick) |=> (presc_cnt_reg == '0))
    else $error("divider did not restart after tick");

  filt_start_a : assert property (
    (ce && !run) |=> filt_out_reg)
    else $error("filter output not asserted at start");

  filt_edge_a : assert property (
    (ce && run && filt_out_reg != in_asserted && !presc_rise)
    |=> $stable(filt_out_reg))
    else $error("filter moved without prescaler edge");

  force_in_a : assert property (
    (ce && !run) |=> in_prev_reg)
    else $error("input not forced asserted");

  disable_clr_a : assert property (
    (ce && !en_reg) |=> (count_reg == '0 && !flag_reg && !hw_trigger))
    else $error("disable did not clear state");

  irq_level_a : assert property (
    (flag_reg && ie_reg) |-> timer_irq)
    else $error("interrupt missing");

  time_match_c : cover property (ce && match && !pulse_mode_reg);
  filt_count_c : cover property (ce && filt_tick);
  capture_c    : cover property (ce && acc_wr && paddr == CNT_OFFSET);

endmodule

// ==== lptimer_pkg.sv ====
// shared constants for the low power timer: register map and fields
// assumes a 32-bit apb slave with byte addresses on paddr
package lptimer_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] CSR_OFFSET = 12'h000;
  localparam logic [11:0] PSR_OFFSET = 12'h004;
  localparam logic [11:0] CMP_OFFSET = 12'h008;
  localparam logic [11:0] CNT_OFFSET = 12'h00c;

  // control_status_register fields
  localparam int CSR_EN_BIT   = 0;
  localparam int CSR_MODE_BIT = 1;
  localparam int CSR_FREE_BIT = 2;
  localparam int CSR_POL_BIT  = 3;
  localparam int CSR_SEL_LSB  = 4;
  localparam int CSR_IE_BIT   = 6;
  localparam int CSR_FLAG_BIT = 7;

  // prescale_register fields
  localparam int PSR_PCS_LSB = 0;
  localparam int PSR_BYP_BIT = 2;
  localparam int PSR_PRE_LSB = 3;

  localparam int SEL_W = 2;
  localparam int PRE_W = 4;
  localparam int SRC_N = 4;
  localparam int PRESC_W = 16;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_RUN  = 3'b100
  } run_state_t;

endpackage

// ==== presc_src_model.sv ====
// prescaler clock sources and pulse pins facing the timer
// assumes the bench switches a source on before it enables the timer
`timescale 1ns/1ps
module presc_src_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] run,
  input  wire logic [3:0] pulse_lvl,
  output logic      [3:0] presc_clk_in,
  output logic      [3:0] pulse_in
);
  logic [3:0] cnt [4];

  // steady running sources
  // source i toggles every 3+i pclk; a stopped source stands low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_clk_in <= 4'h0;
      for (int i = 0; i < 4; i++)
        cnt[i] <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!run[i])
        begin
          presc_clk_in[i] <= 1'b0;
          cnt[i]          <= 4'h0;
        end
        else if (cnt[i] == 4'(2 + i))
        begin
          presc_clk_in[i] <= ~presc_clk_in[i];
          cnt[i]          <= 4'h0;
        end
        else
          cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end

  assign pulse_in = pulse_lvl;
endmodule

// ==== tb.sv ====
// self-checking bench for the low power timer over apb
// assumes zero wait states may occur but waits for pready anyway
`timescale 1ns/1ps
module tb;
  import lptimer_pkg::*;
  logic              pclk = 1'b0;
  logic              ce = 1'b1;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              hw_trigger;
  logic              timer_irq;
  logic [3:0]        presc_clk_in;
  logic [3:0]        pulse_in;
  logic [3:0]        run = 4'h0;
  logic [3:0]        pulse_lvl = 4'h0;
  logic [31:0]       rv;
  logic              er;
  int                num_errors = 0;
  int                compares = 0;
  int                t, hi, per, tk, c, code;

  always #20 pclk = ~pclk;

  low_power_timer low_power_timer_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .presc_clk_in(presc_clk_in), .pulse_in(pulse_in),
    .hw_trigger(hw_trigger), .timer_irq(timer_irq));

  presc_src_model presc_src_model_i (
    .pclk(pclk), .presetn(presetn), .run(run), .pulse_lvl(pulse_lvl),
    .presc_clk_in(presc_clk_in), .pulse_in(pulse_in));

  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // called just after a rising edge; an idle cycle follows each transfer
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    if (n >= 100)
      num_errors++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, er);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rv, er);
    chk(nm, exp, rv);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (hw_trigger !== v && n < 2000);
    if (n >= 2000)
      num_errors++;
  endtask

  // cut a hang short; the longest path needs well under 15000 cycles
  initial
  begin
    repeat (50000) @(posedge pclk);
    num_errors++;
    conclude();
  end

  initial
  begin
    cyc(20);
    presetn <= 1'b1;
    cyc(1);
    rdc("csr rst", CSR_OFFSET, REG_RESET);
    rdc("psr rst", PSR_OFFSET, REG_RESET);
    rdc("cmp rst", CMP_OFFSET, REG_RESET);
    rdc("cnt rst", CNT_OFFSET, REG_RESET);
    chk("trigger", 32'h0, {31'h0, hw_trigger});
    rdc("unmapped", 12'h010, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, er});
    wr(CMP_OFFSET, 32'hFFFF_FFFF);
    rdc("cmp upper", CMP_OFFSET, 32'h0000_FFFF);
    for (int i = 0; i < 4; i++)
    begin
      code = (i == 0) ? 0 : i - 1;
      c    = (i == 0) ? 2 : 1;
      tk   = (i == 0) ? 2 * (3 + i) : (2 * (3 + i)) << (code + 1);
      run <= 4'b0001 << i;
      wr(CSR_OFFSET, 32'h0000_0000);
      wr(PSR_OFFSET, 32'((code << 3) | ((i == 0) << 2) | i));
      wr(CMP_OFFSET, 32'(c));
      wr(CSR_OFFSET, 32'h0000_0001);
      wr(CSR_OFFSET, 32'h0000_0041);
      wait_lvl(1'b1, t);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, per);
      chk("trig high", 32'(tk), 32'(hi));
      chk("trig period", 32'((c + 1) * tk), 32'(hi + per));
      chk("irq set", 32'h1, {31'h0, timer_irq});
      rdc("flag set", CSR_OFFSET, 32'h0000_00C1);
      wr(CSR_OFFSET, 32'h0000_00C1);
      rdc("flag clr", CSR_OFFSET, 32'h0000_0041);
      chk("irq clr", 32'h0, {31'h0, timer_irq});
      wr(CSR_OFFSET, 32'h0000_0000);
      wr(CNT_OFFSET, 32'h0000_0000);
      rdc("cnt off", CNT_OFFSET, 32'h0000_0000);
    end
    run <= 4'b0001;
    wr(PSR_OFFSET, 32'h0000_0004);
    wr(CMP_OFFSET, 32'h0000_0000);
    wr(CSR_OFFSET, 32'h0000_0001);
    wait_lvl(1'b1, t);
    hi = 0;
    repeat (100)
    begin
      @(posedge pclk);
      if (hw_trigger === 1'b1)
        hi++;
    end
    chk("trig hold", 32'd100, 32'(hi));
    wr(CSR_OFFSET, 32'h0000_0000);
    cyc(1);
    chk("trig off", 32'h0, {31'h0, hw_trigger});
    rdc("flag off", CSR_OFFSET, 32'h0000_0000);
    // unfiltered pulses with every prescaler clock stopped
    run       <= 4'b0000;
    pulse_lvl <= 4'b0010;
    wr(CMP_OFFSET, 32'h0000_0100);
    wr(CSR_OFFSET, 32'h0000_0013);
    cyc(10);
    repeat (5)
    begin
      pulse_lvl[1] <= 1'b0;
      cyc(4);
      pulse_lvl[1] <= 1'b1;
      cyc(4);
    end
    cyc(8);
    wr(CNT_OFFSET, 32'h0000_1234);
    rdc("pulse cnt", CNT_OFFSET, 32'h0000_0005);
    pulse_lvl[1] <= 1'b0;
    cyc(4);
    pulse_lvl[1] <= 1'b1;
    cyc(8);
    rdc("capture", CNT_OFFSET, 32'h0000_0005);
    wr(CNT_OFFSET, 32'h0000_0000);
    rdc("recapture", CNT_OFFSET, 32'h0000_0006);
    // a pulse while the clock enable is low must leave no trace
    ce <= 1'b0;
    pulse_lvl[1] <= 1'b0;
    cyc(4);
    pulse_lvl[1] <= 1'b1;
    cyc(4);
    ce <= 1'b1;
    cyc(8);
    wr(CNT_OFFSET, 32'h0000_0000);
    rdc("ce freeze", CNT_OFFSET, 32'h0000_0006);
    // filtered pulses: code 2 needs 4 steady edges of a 6-cycle clock
    wr(CSR_OFFSET, 32'h0000_0000);
    run       <= 4'b0001;
    pulse_lvl <= 4'b0100;
    wr(PSR_OFFSET, 32'h0000_0010);
    wr(CSR_OFFSET, 32'h0000_0023);
    cyc(60);
    wr(CNT_OFFSET, 32'h0000_0000);
    rdc("filt start", CNT_OFFSET, 32'h0000_0000);
    repeat (3)
    begin
      pulse_lvl[2] <= 1'b0;
      cyc(60);
      pulse_lvl[2] <= 1'b1;
      cyc(60);
    end
    pulse_lvl[2] <= 1'b0;
    cyc(6);
    pulse_lvl[2] <= 1'b1;
    cyc(60);
    wr(CNT_OFFSET, 32'h0000_0000);
    rdc("filt cnt", CNT_OFFSET, 32'h0000_0003);
    // active-low input: a low pin at enable is already asserted
    wr(CSR_OFFSET, 32'h0000_0000);
    pulse_lvl[2] <= 1'b0;
    wr(CSR_OFFSET, 32'h0000_002B);
    cyc(60);
    repeat (2)
    begin
      pulse_lvl[2] <= 1'b1;
      cyc(60);
      pulse_lvl[2] <= 1'b0;
      cyc(60);
    end
    wr(CNT_OFFSET, 32'h0000_0000);
    rdc("pol low cnt", CNT_OFFSET, 32'h0000_0002);
    wr(CMP_OFFSET, 32'h0000_0055);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
    rdc("cmp rst2", CMP_OFFSET, 32'h0000_0000);
    conclude();
  end
endmodule
